// >>> pkg/crm_pkg.sv
// shared constants, types and rule summaries for the cdr lock and rate meter control block
//
// Function
// RULE_01: signal loss output is active high when polarity bit is 0, else active low.
// RULE_02: writing 1 then 0 to action bit 5 restarts acquisition, settings kept.
// RULE_03: mode bit 0 set selects lock-to-reference acquisition aid.
// RULE_04: host never sets fine readback and lock-to-reference bits together.
// RULE_05: lock target is data rate over 2^ratio equals reference over 2^range.
// RULE_06: range field bits 7:6 select 19.44, 38.88, 77.76 or 155.52 MHz reference.
// RULE_07: host programs ratio field bits 5:2 to 0101 for every range; the bench writes 0000 there for its rate measurements.
// RULE_08: in lock-to-reference mode a lost lock triggers relock onto the reference.
// RULE_09: host writes 0 then 1 into mode bit 0 to issue lock command.
// RULE_10: measurement returns data over reference ratio within 100 ppm.
// RULE_11: host sets range field to match reference band before measuring.
// RULE_12: measurement mode leaves data locking behaviour untouched.
// RULE_13: fine readback enable is a level and allows repeated measurements.
// RULE_14: writing 1 then 0 to action bit 3 clears done and starts measuring.
// RULE_15: done flag reads 0 while measuring and 1 once the 23-bit result valid.
// RULE_16: result bits 22:16, 15:8, 7:0 sit in high, mid and low registers.
// RULE_17: host computes rate as count times reference over 2^(14+range).
// RULE_18: host trusts a rate readback only while lock lost indicator is low.
// RULE_19: lock lost clears within 250 ppm and sets beyond 1000 ppm error.
// RULE_20: all registers reachable as two-wire subaddresses with autoincrement.
// RULE_21: result stays stable from done until the next measurement starts.
package crm_pkg;
  // register subaddresses
  localparam logic [7:0] SUB_RATE_HIGH    = 8'h00;
  localparam logic [7:0] SUB_RATE_MID     = 8'h01;
  localparam logic [7:0] SUB_RATE_LOW     = 8'h02;
  localparam logic [7:0] SUB_MODE_CONTROL = 8'h03;
  localparam logic [7:0] SUB_ACTION       = 8'h04;
  localparam logic [7:0] SUB_OUT_OPTION   = 8'h05;
  localparam logic [7:0] SUB_MISC_STATUS  = 8'h06;
  localparam logic [7:0] SUB_LAST         = 8'h07;
  // reset values
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_ACTION       = 8'h00;
  localparam logic [7:0] RST_OUT_OPTION   = 8'h00;
  // field positions
  localparam int unsigned MC_LOCK_REF   = 0;
  localparam int unsigned MC_FINE_EN    = 1;
  localparam int unsigned MC_RATIO_LSB  = 2;
  localparam int unsigned MC_RANGE_LSB  = 6;
  localparam int unsigned AC_MEAS_START = 3;
  localparam int unsigned AC_ACQ_RESET  = 5;
  localparam int unsigned OO_SIG_POL    = 2;
  localparam int unsigned MS_SIG_LOSS   = 0;
  localparam int unsigned MS_LOCK_LOST  = 1;
  localparam int unsigned MS_MEAS_DONE  = 2;
  // two-wire slave address parts
  localparam logic       SLV_ADDR_MSB = 1'b1;
  localparam logic [4:0] SLV_ADDR_LOW = 5'h00;
  // lock detector hysteresis in ppm
  localparam logic [11:0] LOCK_CLEAR_PPM = 12'h0FA;
  localparam logic [11:0] LOCK_SET_PPM   = 12'h3E8;
  // rate measurement geometry
  localparam int unsigned WIN_BASE_LOG2  = 14;
  localparam int unsigned REF_PRE_LOG2   = 4;
  localparam int unsigned DATA_PRE_LOG2  = 6;
  localparam int unsigned RATE_W         = 23;
  localparam int unsigned DCNT_W         = RATE_W - DATA_PRE_LOG2;
  localparam int unsigned WCNT_W         = 13;
  // two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_SUB  = 3'b010,
    ST_WR   = 3'b011,
    ST_ACK  = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110
  } crm_i2c_st_t;
endpackage

// >>> pkg/crm_meas_if.sv
// control and result signals between the register block and the rate meter
`timescale 1ns/1ps
`default_nettype none
interface crm_meas_if;
  logic        start;
  logic        enable;
  logic [1:0]  range;
  logic        done;
  logic [22:0] count;
  modport ctrl  (output start, enable, range, input done, count);
  modport meter (input start, enable, range, output done, count);
endinterface
`default_nettype wire

// >>> logic/crm_rate_meter.sv
// data rate meter counting divided data edges over a reference window
`timescale 1ns/1ps
`default_nettype none
module crm_rate_meter
  import crm_pkg::*;
(
  // clock, reset and enable
  input  wire logic  i_ref_clk,
  input  wire logic  i_rst_n,
  input  wire logic  i_clk_en,
  // divided clocks from the analog front end
  input  wire logic  i_ref_div_clk,
  input  wire logic  i_data_div_clk,
  // control and result
  crm_meas_if.meter  meas
);
  logic [2:0]        ref_sync_reg;
  logic [2:0]        dat_sync_reg;
  logic              ref_edge;
  logic              dat_edge;
  logic              busy_reg,    busy_next;
  logic              done_reg,    done_next;
  logic              arm_reg,     arm_next;
  logic [WCNT_W-1:0] win_cnt_reg, win_cnt_next;
  logic [WCNT_W-1:0] win_last;
  logic [DCNT_W-1:0] dat_cnt_reg, dat_cnt_next;
  logic [RATE_W-1:0] result_reg,  result_next;

  // rising edges seen after two synchroniser stages
  assign ref_edge = ref_sync_reg[1] & ~ref_sync_reg[2];
  assign dat_edge = dat_sync_reg[1] & ~dat_sync_reg[2];

  // window of 2^(14+range) reference cycles, counted after the prescaler
  assign win_last = WCNT_W'((1 << (WIN_BASE_LOG2 - REF_PRE_LOG2 + meas.range)) - 1); // RULE_17

  // measurement sequencing
  always_comb begin
    busy_next    = busy_reg;
    arm_next     = arm_reg;
    done_next    = done_reg;
    win_cnt_next = win_cnt_reg;
    dat_cnt_next = dat_cnt_reg;
    result_next  = result_reg;
    if (meas.start && meas.enable) begin // RULE_14 RULE_13
      busy_next    = 1'b1;
      arm_next     = 1'b1; // window opens on a ref edge
      done_next    = 1'b0; // RULE_15
      win_cnt_next = '0;
      dat_cnt_next = '0;
    end else if (busy_reg && !meas.enable) begin
      busy_next = 1'b0; // abandoned, done stays low
    end else if (busy_reg && arm_reg) begin
      arm_next = ~ref_edge; // RULE_10
    end else if (busy_reg) begin
      if (dat_edge && (dat_cnt_reg != '1)) begin
        dat_cnt_next = dat_cnt_reg + 1'b1;
      end
      if (ref_edge) begin
        win_cnt_next = win_cnt_reg + 1'b1;
        if (win_cnt_reg == win_last) begin
          busy_next   = 1'b0;
          done_next   = 1'b1; // RULE_15
          result_next = {dat_cnt_next, {DATA_PRE_LOG2{1'b0}}}; // RULE_10 RULE_21
        end
      end
    end
  end

  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ref_sync_reg <= 3'h0;
      dat_sync_reg <= 3'h0;
      busy_reg     <= 1'b0;
      arm_reg      <= 1'b0;
      done_reg     <= 1'b0;
      win_cnt_reg  <= '0;
      dat_cnt_reg  <= '0;
      result_reg   <= '0;
    end else if (i_clk_en) begin
      ref_sync_reg <= {ref_sync_reg[1:0], i_ref_div_clk};
      dat_sync_reg <= {dat_sync_reg[1:0], i_data_div_clk};
      busy_reg     <= busy_next;
      arm_reg      <= arm_next;
      done_reg     <= done_next;
      win_cnt_reg  <= win_cnt_next;
      dat_cnt_reg  <= dat_cnt_next;
      result_reg   <= result_next;
    end
  end

  assign meas.done  = done_reg;
  assign meas.count = result_reg;
endmodule
`default_nettype wire

// >>> logic/crm_top.sv
// cdr control block: two-wire register slave, lock control and rate meter
`timescale 1ns/1ps
`default_nettype none
module crm_top
  import crm_pkg::*;
(
  // clock, reset and enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // two-wire management bus
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda,
  output logic             o_sda_oe_n,
  input  wire logic        i_slave_addr_sel,
  // analog front end status
  input  wire logic        i_sig_loss_detect,
  input  wire logic [11:0] i_rate_err_ppm,
  input  wire logic        i_ref_div_clk,
  input  wire logic        i_data_div_clk,
  // pins and pll controls
  output logic             o_signal_loss_output,
  output logic             o_lock_lost_indicator,
  output logic             o_lock_to_ref_mode,
  output logic [1:0]       o_ref_range,
  output logic [3:0]       o_ref_ratio,
  output logic             o_acq_start
);
  crm_meas_if meas ();

  // synchronised pin inputs
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [1:0]  sig_sync_reg;
  logic [1:0]  asel_sync_reg;
  logic [11:0] err_sync1_reg;
  logic [11:0] err_sync2_reg;
  logic        scl_s;
  logic        sda_s;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic [6:0]  slave_addr;

  // two-wire slave and register state
  crm_i2c_st_t st_reg,           st_next;
  crm_i2c_st_t ret_reg,          ret_next;
  logic [3:0]  cnt_reg,          cnt_next;
  logic [7:0]  sh_reg,           sh_next;
  logic [2:0]  ptr_reg,          ptr_next;
  logic [2:0]  ptr_inc;
  logic        nack_reg,         nack_next;
  logic        sda_oe_n_reg,     sda_oe_n_next;
  logic [7:0]  reference_clock_input_mode_control_reg, reference_clock_input_mode_control_next;
  logic [7:0]  action_control_reg,      action_control_next;
  logic [7:0]  output_option_control_reg, output_option_control_next;
  logic        meas_start_reg,   meas_start_next;
  logic        acq_cmd;
  logic        lock_cmd;
  logic [7:0]  misc_rd;
  logic [63:0] rd_vec;

  // lock control state
  logic        lock_lost_reg,    lock_lost_next;
  logic        acq_reg,          acq_next;
  logic        sig_out_reg,      sig_out_next;

  // pick one register byte out of the read map
  function automatic logic [7:0] rd_sel(input logic [2:0] p, input logic [63:0] v);
    rd_sel = v[{p, 3'b000} +: 8];
  endfunction

  // bus line conditions from the second and third stages
  assign scl_s      = scl_sync_reg[1];
  assign sda_s      = sda_sync_reg[1];
  assign scl_rise   = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall   = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign bus_start  = scl_s & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_s;
  assign bus_stop   = scl_s & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_s;
  assign slave_addr = {SLV_ADDR_MSB, asel_sync_reg[1], SLV_ADDR_LOW};
  assign ptr_inc    = (ptr_reg == SUB_LAST[2:0]) ? ptr_reg : ptr_reg + 3'h1;

  // read map, one byte per subaddress
  always_comb begin
    misc_rd               = 8'h00;
    misc_rd[MS_SIG_LOSS]  = sig_sync_reg[1];
    misc_rd[MS_LOCK_LOST] = lock_lost_reg;
    misc_rd[MS_MEAS_DONE] = meas.done; // RULE_15
    rd_vec                = 64'h0;
    rd_vec[{SUB_RATE_HIGH[2:0], 3'b000} +: 8]    = {1'b0, meas.count[22:16]}; // RULE_16
    rd_vec[{SUB_RATE_MID[2:0], 3'b000} +: 8]     = meas.count[15:8]; // RULE_16
    rd_vec[{SUB_RATE_LOW[2:0], 3'b000} +: 8]     = meas.count[7:0]; // RULE_16
    rd_vec[{SUB_MODE_CONTROL[2:0], 3'b000} +: 8] = reference_clock_input_mode_control_reg;
    rd_vec[{SUB_ACTION[2:0], 3'b000} +: 8]       = action_control_reg;
    rd_vec[{SUB_OUT_OPTION[2:0], 3'b000} +: 8]   = output_option_control_reg;
    rd_vec[{SUB_MISC_STATUS[2:0], 3'b000} +: 8]  = misc_rd;
  end

  // two-wire slave with autoincrementing subaddress
  always_comb begin
    st_next                    = st_reg;
    ret_next                   = ret_reg;
    cnt_next                   = cnt_reg;
    sh_next                    = sh_reg;
    ptr_next                   = ptr_reg;
    nack_next                  = nack_reg;
    reference_clock_input_mode_control_next   = reference_clock_input_mode_control_reg;
    action_control_next        = action_control_reg;
    output_option_control_next = output_option_control_reg;
    meas_start_next            = 1'b0;
    acq_cmd                    = 1'b0;
    lock_cmd                   = 1'b0;
    if (bus_stop) begin
      st_next = ST_IDLE;
    end else if (bus_start) begin
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          cnt_next = 4'h0;
        end
        ST_ADDR, ST_SUB, ST_WR: begin
          if (scl_rise) begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && (cnt_reg == 4'h8)) begin
            cnt_next = 4'h0;
            st_next  = ST_ACK;
            if (st_reg == ST_ADDR) begin
              ret_next = sh_reg[0] ? ST_RD : ST_SUB;
              if (sh_reg[7:1] != slave_addr) begin
                st_next = ST_IDLE; // not ours, stay off the bus
              end
            end else if (st_reg == ST_SUB) begin
              ret_next = ST_WR;
              ptr_next = sh_reg[2:0]; // RULE_20
              if (sh_reg > SUB_LAST) begin
                st_next = ST_IDLE; // bad subaddress, no acknowledge
              end
            end else begin
              ret_next = ST_WR;
              ptr_next = ptr_inc; // RULE_20
              case (ptr_reg)
                SUB_MODE_CONTROL[2:0]: begin
                  reference_clock_input_mode_control_next = sh_reg;
                  lock_cmd = ~reference_clock_input_mode_control_reg[MC_LOCK_REF] & sh_reg[MC_LOCK_REF]; // RULE_09
                end
                SUB_ACTION[2:0]: begin
                  action_control_next = sh_reg;
                  acq_cmd = action_control_reg[AC_ACQ_RESET] & ~sh_reg[AC_ACQ_RESET]; // RULE_02
                  meas_start_next = action_control_reg[AC_MEAS_START] & ~sh_reg[AC_MEAS_START]; // RULE_14
                end
                SUB_OUT_OPTION[2:0]: begin
                  output_option_control_next = sh_reg;
                end
                default: begin
                  cnt_next = 4'h0; // read-only bytes ignore writes
                end
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            st_next = ret_reg;
            if (ret_reg == ST_RD) begin
              sh_next = rd_sel(ptr_reg, rd_vec);
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              cnt_next = 4'h0;
              st_next  = ST_RACK;
            end else begin
              cnt_next = cnt_reg + 4'h1;
              sh_next  = {sh_reg[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nack_next = sda_s;
          end else if (scl_fall) begin
            if (nack_reg) begin
              st_next = ST_IDLE; // master ends the read
            end else begin
              ptr_next = ptr_inc; // RULE_20
              sh_next  = rd_sel(ptr_inc, rd_vec);
              st_next  = ST_RD;
            end
          end
        end
        default: begin
          st_next = ST_IDLE;
        end
      endcase
    end
    // pull the line low for acknowledge and for zero data bits
    sda_oe_n_next = !((st_next == ST_ACK) || ((st_next == ST_RD) && !sh_next[7]));
  end

  // two-wire slave and register flops
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scl_sync_reg              <= 3'h7;
      sda_sync_reg              <= 3'h7;
      sig_sync_reg              <= 2'h0;
      asel_sync_reg             <= 2'h0;
      err_sync1_reg             <= 12'hFFF;
      err_sync2_reg             <= 12'hFFF;
      st_reg                    <= ST_IDLE;
      ret_reg                   <= ST_IDLE;
      cnt_reg                   <= 4'h0;
      sh_reg                    <= 8'h00;
      ptr_reg                   <= 3'h0;
      nack_reg                  <= 1'b0;
      sda_oe_n_reg              <= 1'b1;
      reference_clock_input_mode_control_reg   <= RST_MODE_CONTROL;
      action_control_reg        <= RST_ACTION;
      output_option_control_reg <= RST_OUT_OPTION;
      meas_start_reg            <= 1'b0;
    end else if (i_clk_en) begin
      scl_sync_reg              <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg              <= {sda_sync_reg[1:0], i_sda};
      sig_sync_reg              <= {sig_sync_reg[0], i_sig_loss_detect};
      asel_sync_reg             <= {asel_sync_reg[0], i_slave_addr_sel};
      err_sync1_reg             <= i_rate_err_ppm;
      err_sync2_reg             <= err_sync1_reg;
      st_reg                    <= st_next;
      ret_reg                   <= ret_next;
      cnt_reg                   <= cnt_next;
      sh_reg                    <= sh_next;
      ptr_reg                   <= ptr_next;
      nack_reg                  <= nack_next;
      sda_oe_n_reg              <= sda_oe_n_next;
      reference_clock_input_mode_control_reg   <= reference_clock_input_mode_control_next;
      action_control_reg        <= action_control_next;
      output_option_control_reg <= output_option_control_next;
      meas_start_reg            <= meas_start_next;
    end
  end

  // lock detector hysteresis, acquisition restarts and signal loss polarity
  always_comb begin
    lock_lost_next = lock_lost_reg;
    if (err_sync2_reg <= LOCK_CLEAR_PPM) begin
      lock_lost_next = 1'b0; // RULE_19
    end else if (err_sync2_reg > LOCK_SET_PPM) begin
      lock_lost_next = 1'b1; // RULE_19
    end
    acq_next = acq_cmd | lock_cmd // RULE_02 RULE_09
             | (lock_lost_next & ~lock_lost_reg & reference_clock_input_mode_control_reg[MC_LOCK_REF]); // RULE_08
    sig_out_next = sig_sync_reg[1] ^ output_option_control_reg[OO_SIG_POL]; // RULE_01
  end

  // lock control flops
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      lock_lost_reg <= 1'b1;
      acq_reg       <= 1'b0;
      sig_out_reg   <= 1'b0;
    end else if (i_clk_en) begin
      lock_lost_reg <= lock_lost_next;
      acq_reg       <= acq_next;
      sig_out_reg   <= sig_out_next;
    end
  end

  // measurement control, independent of the locking path
  assign meas.start  = meas_start_reg;
  assign meas.enable = reference_clock_input_mode_control_reg[MC_FINE_EN]; // RULE_13 RULE_12
  assign meas.range  = reference_clock_input_mode_control_reg[MC_RANGE_LSB +: 2];

  crm_rate_meter u_meter (
    .i_ref_clk      (i_ref_clk),
    .i_rst_n        (i_rst_n),
    .i_clk_en       (i_clk_en),
    .i_ref_div_clk  (i_ref_div_clk),
    .i_data_div_clk (i_data_div_clk),
    .meas           (meas)
  );

  // pin and pll control outputs
  assign o_sda                 = 1'b0;
  assign o_sda_oe_n            = sda_oe_n_reg;
  assign o_signal_loss_output  = sig_out_reg;
  assign o_lock_lost_indicator = lock_lost_reg;
  assign o_lock_to_ref_mode    = reference_clock_input_mode_control_reg[MC_LOCK_REF]; // RULE_03 RULE_12
  assign o_ref_range           = reference_clock_input_mode_control_reg[MC_RANGE_LSB +: 2]; // RULE_06 RULE_05
  assign o_ref_ratio           = reference_clock_input_mode_control_reg[MC_RATIO_LSB +: 4]; // RULE_05
  assign o_acq_start           = acq_reg;
endmodule
`default_nettype wire

// >>> dv/crm_monitor.sv
// concurrent port checks for the cdr lock and rate meter control block
`timescale 1ns/1ps
`default_nettype none
module crm_monitor (
  // clock, reset and enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  // bus and front end inputs
  input  wire logic        i_scl,
  input  wire logic        i_sig_loss_detect,
  input  wire logic [11:0] i_rate_err_ppm,
  // watched outputs
  input  wire logic        o_sda_oe_n,
  input  wire logic        o_signal_loss_output,
  input  wire logic        o_lock_lost_indicator,
  input  wire logic        o_lock_to_ref_mode,
  input  wire logic [1:0]  o_ref_range,
  input  wire logic [3:0]  o_ref_ratio,
  input  wire logic        o_acq_start
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n || !i_clk_en);

  // restart request is one cycle wide and leaves the settings alone
  a_acq_single_pulse: assert property (o_acq_start |=> !o_acq_start)
    else $error("acquisition start wider than one cycle");
  a_settings_kept: assert property (o_acq_start |=> ($stable(o_ref_range) && $stable(o_ref_ratio)) [*3])
    else $error("settings moved around an acquisition restart");
  // entering lock to reference issues a lock command
  a_lock_cmd: assert property ($rose(o_lock_to_ref_mode) |-> ##[0:3] o_acq_start)
    else $error("no acquisition start after entering lock to reference");
  a_relock_ref: assert property ($rose(o_lock_lost_indicator) && o_lock_to_ref_mode |-> ##[0:3] o_acq_start)
    else $error("no relock after lock lost in lock to reference mode");
  // lock lost hysteresis, windows wait out the input synchronisers
  a_lock_set: assert property ((i_rate_err_ppm > 12'h3E8) [*4] ##0 $past(i_rst_n, 6) |-> o_lock_lost_indicator)
    else $error("lock lost low with large error");
  a_lock_clear: assert property ((i_rate_err_ppm <= 12'h0FA) [*4] ##0 $past(i_rst_n, 6) |-> !o_lock_lost_indicator)
    else $error("lock lost high with small error");
  a_lock_hold: assert property ((i_rate_err_ppm > 12'h0FA && i_rate_err_ppm <= 12'h3E8) [*5] |-> $stable(o_lock_lost_indicator))
    else $error("lock lost moved inside the hysteresis band");
  // loss output only follows its input or a register write
  a_loss_stable: assert property (($stable(i_sig_loss_detect) && i_scl) [*6] ##0 $past(i_rst_n, 8) |-> $stable(o_signal_loss_output))
    else $error("loss output moved without cause");
  // data pin only changes while the bus clock is low
  a_sda_scl_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
    else $error("data pin changed with bus clock high");

  // main scenarios reached
  c_relock: cover property ($rose(o_lock_lost_indicator) && o_lock_to_ref_mode);
  c_acq: cover property (o_acq_start);
  c_ack: cover property ($fell(o_sda_oe_n));
endmodule
bind crm_top crm_monitor i_crm_monitor (.*);
`default_nettype wire

// >>> dv/crm_host_model.sv
// two-wire bus host that drives the management port of the control block
`timescale 1ns/1ps
`default_nettype none
module crm_host_model (
  // clock and wire level
  input  wire logic i_ref_clk,
  input  wire logic i_sda,
  // host pins, low on o_sda_drv_n pulls the wire
  output var logic  o_scl,
  output var logic  o_sda_drv_n
);
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda_drv_n = 1'b1;
  end
  // wait n clock edges
  task automatic hc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  // one bit: data set with clock low, sampled at the end of the high phase
  task automatic bitx(input logic b, output logic r);
    o_sda_drv_n <= b;
    hc(8);
    o_scl <= 1'b1;
    hc(8);
    r = i_sda;
    o_scl <= 1'b0;
    hc(1);
  endtask
  // start: data falls while clock is high
  task automatic start();
    o_sda_drv_n <= 1'b1;
    hc(8);
    o_scl <= 1'b1;
    hc(8);
    o_sda_drv_n <= 1'b0;
    hc(8);
    o_scl <= 1'b0;
    hc(1);
  endtask
  // stop: data rises while clock is high
  task automatic stop();
    o_sda_drv_n <= 1'b0;
    hc(8);
    o_scl <= 1'b1;
    hc(8);
    o_sda_drv_n <= 1'b1;
    hc(8);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic bytex(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
  // write one register, nak set if any byte went unacknowledged
  task automatic wr(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       k0, k1, k2;
    start();
    bytex({a, 1'b0}, 1'b1, q, k0);
    bytex(s, 1'b1, q, k1);
    bytex(d, 1'b1, q, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  // read one register through a repeated start, closed by a no-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] s, output logic [7:0] d);
    logic [7:0] q;
    logic       k;
    start();
    bytex({a, 1'b0}, 1'b1, q, k);
    bytex(s, 1'b1, q, k);
    start();
    bytex({a, 1'b1}, 1'b1, q, k);
    bytex(8'hFF, 1'b1, d, k);
    stop();
  endtask
endmodule
`default_nettype wire

// >>> dv/test_cdr_reference_clock_input_lock_and_rate_meter.sv
// self-checking bench: registers, loss polarity, lock control and rate measurement
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module test_cdr_reference_clock_input_lock_and_rate_meter;
  import crm_pkg::*;
  // stimulus, observed pins and bookkeeping
  logic        i_ref_clk         = 1'b0;
  logic        i_rst_n           = 1'b0;
  logic        i_sig_loss_detect = 1'b0;
  logic [11:0] i_rate_err_ppm    = 12'h000;
  logic        i_ref_div_clk     = 1'b0;
  logic        i_data_div_clk    = 1'b0;
  logic        scl, drv_n, o_sda, o_sda_oe_n, loss_o, lol_o, ltr_o, acq, nak;
  logic [1:0]  rng;
  logic [3:0]  rat;
  logic [7:0]  rb, hi, mid, lo;
  logic [22:0] got, ex;
  wire         sda;
  int          n_fail = 0, checks = 0, cyc = 0, n_acq = 0, n0;
  logic [11:0] errs [5] = '{12'h7D0, 12'h1F4, 12'h0FA, 12'h3E8, 12'h3E9};
  logic        lols [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic [6:0] DEV = {SLV_ADDR_MSB, 1'b0, SLV_ADDR_LOW};

  // clocks: system, divided reference 5 MHz, divided data 10 MHz
  always #12.5 i_ref_clk = ~i_ref_clk;
  always #100 i_ref_div_clk = ~i_ref_div_clk;
  always #50 i_data_div_clk = ~i_data_div_clk;
  // open-drain wire with pull-up
  assign sda = drv_n & (o_sda_oe_n | o_sda);

  crm_top i_crm_top (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_slave_addr_sel(1'b0), .i_sig_loss_detect(i_sig_loss_detect),
    .i_rate_err_ppm(i_rate_err_ppm), .i_ref_div_clk(i_ref_div_clk), .i_data_div_clk(i_data_div_clk),
    .o_signal_loss_output(loss_o), .o_lock_lost_indicator(lol_o), .o_lock_to_ref_mode(ltr_o),
    .o_ref_range(rng), .o_ref_ratio(rat), .o_acq_start(acq));
  crm_host_model i_crm_host_model (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl), .o_sda_drv_n(drv_n));

  // verdict and end of run
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // register access through the host model
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    i_crm_host_model.wr(DEV, s, d, nak);
    `CHK("ack", 1'b0, nak)
  endtask
  task automatic rd(input logic [7:0] s);
    i_crm_host_model.rd(DEV, s, rb);
  endtask

  // restart pulse count and run time ceiling
  always @(posedge i_ref_clk) begin
    cyc++;
    if (acq === 1'b1) n_acq++;
    if (cyc == 90000) begin
      n_fail++;
      close_out();
    end
  end

  // main sequence
  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rd(SUB_OUT_OPTION);
    `CHK("option reset", RST_OUT_OPTION, rb)
    for (int p = 0; p < 2; p++) begin
      wr(SUB_OUT_OPTION, {5'h00, p[0], 2'h0});
      for (int l = 0; l < 2; l++) begin
        i_sig_loss_detect <= l[0];
        repeat (5) @(posedge i_ref_clk);
        `CHK("loss out", l[0] ^ p[0], loss_o)
      end
    end
    foreach (errs[k]) begin
      i_rate_err_ppm <= errs[k];
      repeat (5) @(posedge i_ref_clk);
      `CHK("lock lost", lols[k], lol_o)
    end
    i_rate_err_ppm <= 12'h064;
    n0 = n_acq;
    wr(SUB_MODE_CONTROL, 8'h55);
    `CHK("lock mode", 1'b1, ltr_o)
    `CHK("range", 2'h1, rng)
    `CHK("ratio", 4'h5, rat)
    `CHK("lock cmd", n0 + 1, n_acq)
    i_rate_err_ppm <= 12'h7D0;
    repeat (6) @(posedge i_ref_clk);
    `CHK("relock", n0 + 2, n_acq)
    i_rate_err_ppm <= 12'h064;
    wr(SUB_ACTION, 8'h20);
    `CHK("restart early", n0 + 2, n_acq)
    wr(SUB_ACTION, 8'h00);
    `CHK("restart", n0 + 3, n_acq)
    rd(SUB_MODE_CONTROL);
    `CHK("mode kept", 8'h55, rb)
    i_crm_host_model.wr(DEV, SUB_LAST + 8'h01, 8'h00, nak);
    `CHK("bad subaddr", 1'b1, nak)
    i_crm_host_model.wr(7'h60, SUB_MODE_CONTROL, 8'h00, nak);
    `CHK("bad device", 1'b1, nak)
    for (int r = 0; r < 2; r++) begin
      wr(SUB_MODE_CONTROL, {r[1:0], 6'h02});
      wr(SUB_ACTION, 8'h08);
      wr(SUB_ACTION, 8'h00);
      rd(SUB_MISC_STATUS);
      `CHK("done clear", 1'b0, rb[MS_MEAS_DONE])
      for (int t = 0; t < 40 && rb[MS_MEAS_DONE] !== 1'b1; t++) rd(SUB_MISC_STATUS);
      `CHK("done", 1'b1, rb[MS_MEAS_DONE])
      `CHK("lock lost", 1'b0, rb[MS_LOCK_LOST])
      rd(SUB_RATE_HIGH);
      hi = rb;
      rd(SUB_RATE_MID);
      mid = rb;
      rd(SUB_RATE_LOW);
      lo = rb;
      got = {hi[6:0], mid, lo};
      ex = 23'h000001 << (17 + r);
      `CHK("high bit7", 1'b0, hi[7])
      `CHK("rate", 1'b1, got + 23'h40 >= ex && got <= ex + 23'h40)
      rd(SUB_RATE_HIGH);
      `CHK("rate held", hi, rb)
    end
    `CHK("no restart", n0 + 3, n_acq)
    wr(SUB_RATE_LOW, ~lo);
    rd(SUB_RATE_LOW);
    `CHK("read only", lo, rb)
    close_out();
  end
endmodule
`default_nettype wire
